// >>> dpb_bus_if.sv
/*
 Differential I/O pack: channel control, interrupts, acknowledge and APB registers.
 Assumes an APB master on MCLK, line transceivers outside, and a host raising INTSEL.
*/
// Register access over APB and the register offsets were chosen for this implementation.
`default_nettype none

module dpb_bus_if #(
	parameter int CHANNELS = 24,
	parameter logic [7:0] ID_MAKER = 8'h5A,
	parameter logic [7:0] ID_MODEL = 8'h3C
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [23:0] CH_RX,
	output var dpb_pkg::dpb_pins_t CH_PINS,
	input wire logic INTSEL,
	input wire logic IACK_A1,
	output var dpb_pkg::dpb_iack_t IACK,
	output logic IRQ_LINE_ZERO_N
);
	import dpb_pkg::*;

	// ==========================================================
	// Helpers
	// Identification byte for index i (ID_MAKER and ID_MODEL are arbitrary).
	function automatic logic [7:0] id_byte(input logic [4:0] i);
		logic [7:0] b;
		b = 8'h00;
		case (i)
			5'h00: b = 8'h49;
			5'h01: b = 8'h50;
			5'h02: b = 8'h41;
			5'h03: b = 8'h43;
			5'h04: b = ID_MAKER;
			5'h05: b = ID_MODEL;
			5'h06: b = 8'h00;
			5'h07: b = 8'h00;
			5'h08: b = 8'h00;
			5'h09: b = 8'h00;
			5'h0A: b = 8'h00;
			5'h0B: b = 8'h0C;
			5'h0C: b = 8'h00;
			5'h0D: b = 8'h00;
			5'h0E: b = 8'h00;
			5'h0F: b = 8'h00;
			5'h10: b = 8'h00;
			5'h11: b = 8'h00;
			5'h12: b = 8'h00;
			5'h13: b = 8'h00;
			5'h14: b = 8'h00;
			5'h15: b = 8'h00;
			5'h16: b = 8'h00;
			5'h17: b = 8'h00;
			5'h18: b = 8'h00;
			5'h19: b = 8'h00;
			5'h1A: b = 8'h00;
			5'h1B: b = 8'h00;
			5'h1C: b = 8'h00;
			5'h1D: b = 8'h00;
			5'h1E: b = 8'h00;
			5'h1F: b = 8'h00;
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	function automatic logic [31:0] zext24(input logic [23:0] v);
		return {8'h00, v};
	endfunction

	// ==========================================================
	// Registers
	logic [23:0] out_data;
	logic [23:0] dir;
	logic [23:0] int_en;
	logic [23:0] int_type;
	logic [23:0] int_pol;
	logic [23:0] int_stat;
	logic [7:0] int_vec;
	logic [23:0] rx_meta;
	logic [23:0] rx_sync;
	logic [23:0] rx_prev;
	logic [23:0] hit;
	logic setup;
	logic wr_en;
	logic soft_rst;
	logic mapped;
	logic [31:0] next_rdata;
	logic intsel_prev;
	logic ack_start;

	assign setup = PSEL && !PENABLE;
	// Writes commit in the access cycle; the slave never stalls.
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign soft_rst = wr_en && (PADDR == OFF_SOFT_RST) && PWDATA[0];

	// ==========================================================
	// Input synchronisation
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rx_meta <= RST_CHAN;
			rx_sync <= RST_CHAN;
		end else begin
			rx_meta <= CH_RX;
			rx_sync <= rx_meta;
		end
	end

	// Previous synchronised sample for change-of-state detection.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rx_prev <= RST_CHAN;
		end else begin
			rx_prev <= rx_sync;
		end
	end

	// ==========================================================
	// Channel control
	always_ff @(posedge MCLK) begin
		if (RST || soft_rst) begin
			dir <= RST_CHAN;
		end else if (wr_en && PADDR == OFF_DIR) begin
			dir <= PWDATA[23:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST || soft_rst) begin
			out_data <= RST_CHAN;
		end else if (wr_en && PADDR == OFF_DATA) begin
			out_data <= PWDATA[23:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			CH_PINS <= '0;
		end else begin
			// One line pair per channel: drive only when set to output.
			CH_PINS.drive_en <= dir;
			// Logic 1 drives A above B, logic 0 drives A below B.
			CH_PINS.tx <= out_data & dir;
		end
	end

	// ==========================================================
	// Interrupt configuration
	always_ff @(posedge MCLK) begin
		if (RST) begin
			int_en <= RST_CHAN;
		end else if (wr_en && PADDR == OFF_INT_EN) begin
			int_en <= PWDATA[23:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			int_type <= RST_CHAN;
		end else if (wr_en && PADDR == OFF_INT_TYPE) begin
			int_type <= PWDATA[23:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			int_pol <= RST_CHAN;
		end else if (wr_en && PADDR == OFF_INT_POL) begin
			int_pol <= PWDATA[23:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			int_vec <= RST_VEC;
		end else if (wr_en && PADDR == OFF_INT_VEC) begin
			int_vec <= PWDATA[7:0];
		end
	end

	// ==========================================================
	// Interrupt detection and status
	always_comb begin
		hit = '0;
		for (int i = 0; i < CHANNELS; i++) begin
			if (int_type[i]) begin
				hit[i] = rx_sync[i] ^ rx_prev[i];
			end else begin
				hit[i] = ~(rx_sync[i] ^ int_pol[i]);
			end
		end
		hit = hit & int_en & ~dir;
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			int_stat <= RST_CHAN;
		end else if (wr_en && PADDR == OFF_INT_STAT) begin
			// Clear by one, and a new or lasting condition wins.
			int_stat <= (int_stat & ~PWDATA[23:0]) | hit;
		end else begin
			int_stat <= int_stat | hit;
		end
	end

	// Request line zero only; a few cycles from pin to line.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			IRQ_LINE_ZERO_N <= 1'b1;
		end else begin
			IRQ_LINE_ZERO_N <= ~|(int_stat & int_en);
		end
	end

	// ==========================================================
	// Interrupt acknowledge
	always_ff @(posedge MCLK) begin
		if (RST) begin
			intsel_prev <= 1'b0;
		end else begin
			intsel_prev <= INTSEL;
		end
	end

	// A new select with A1 low starts an acknowledge.
	assign ack_start = INTSEL && !intsel_prev && !IACK_A1;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			IACK <= '0;
		end else begin
			IACK.ack <= 1'b0;
			if (ack_start) begin
				IACK.vec <= int_vec;
				IACK.vec_oe <= 1'b1;
				IACK.ack <= 1'b1;
			end else if (!INTSEL) begin
				IACK.vec_oe <= 1'b0;
			end
		end
	end

	// ==========================================================
	// APB read decode
	always_comb begin
		next_rdata = 32'h00000000;
		mapped = 1'b1;
		if (PADDR == OFF_DATA) begin
			next_rdata = zext24(rx_sync);
		end else if (PADDR == OFF_DIR) begin
			next_rdata = zext24(dir);
		end else if (PADDR == OFF_INT_EN) begin
			next_rdata = zext24(int_en);
		end else if (PADDR == OFF_INT_TYPE) begin
			next_rdata = zext24(int_type);
		end else if (PADDR == OFF_INT_POL) begin
			next_rdata = zext24(int_pol);
		end else if (PADDR == OFF_INT_STAT) begin
			next_rdata = zext24(int_stat);
		end else if (PADDR == OFF_INT_VEC) begin
			next_rdata = {24'h000000, int_vec};
		end else if (PADDR == OFF_SOFT_RST) begin
			next_rdata = 32'h00000000;
		end else if (PADDR >= OFF_ID_BASE && PADDR[1:0] == 2'b00) begin
			// One identification byte per word, low lane.
			next_rdata = {24'h000000, id_byte(PADDR[6:2])};
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			PREADY <= 1'b0;
		end else begin
			PREADY <= 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			PRDATA <= 32'h00000000;
		end else if (setup) begin
			PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			PSLVERR <= 1'b0;
		end else if (setup) begin
			PSLVERR <= ~mapped;
		end
	end

endmodule

`default_nettype wire

// >>> dpb_host.sv
/* Carrier host model running acknowledge cycles. Assumes the block's clock. */
`default_nettype none
module dpb_host (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire dpb_pkg::dpb_iack_t ack,
	output logic intsel,
	output logic [7:0] vec,
	output logic got
);
	import dpb_pkg::*;
	logic [2:0] cnt;
	// ==========================================================
	// Acknowledge cycle with a give-up count.
	always_ff @(posedge clk) begin
		cnt <= go ? 3'h0 : cnt + 3'h1;
		if (rst || (intsel && cnt == 3'h4)) begin
			intsel <= 1'b0;
			got <= 1'b0;
		end else if (go) begin
			intsel <= 1'b1;
			got <= 1'b0;
		end else if (intsel && ack.ack) begin
			intsel <= 1'b0;
			got <= 1'b1;
			vec <= ack.vec;
		end
	end
endmodule
`default_nettype wire

// >>> dpb_pkg.sv
/*
 Constants, register offsets and types for the differential I/O pack bus block.
 Assumes a single 25 MHz clock with a synchronous active-high reset.
*/
`default_nettype none

package dpb_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_DATA = 8'h00;
	localparam logic [7:0] OFF_DIR = 8'h04;
	localparam logic [7:0] OFF_INT_EN = 8'h08;
	localparam logic [7:0] OFF_INT_TYPE = 8'h0C;
	localparam logic [7:0] OFF_INT_POL = 8'h10;
	localparam logic [7:0] OFF_INT_STAT = 8'h14;
	localparam logic [7:0] OFF_INT_VEC = 8'h18;
	localparam logic [7:0] OFF_SOFT_RST = 8'h1C;
	localparam logic [7:0] OFF_ID_BASE = 8'h80;
	localparam int ID_BYTES = 32;

	// ==========================================================
	// Reset values
	localparam logic [23:0] RST_CHAN = 24'h000000;
	localparam logic [7:0] RST_VEC = 8'h00;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 25000000;
	localparam int BUS_HZ = 8000000;
	localparam int BUS_CYCLE_NS = 250;
	localparam int IRQ_MAX_NS = 2250;
	localparam int IRQ_MAX_CYC = (IRQ_MAX_NS * (CLK_HZ / 1000000)) / 1000;

	// ==========================================================
	// Channel pin group.
	typedef struct packed {
		logic [23:0] drive_en;
		logic [23:0] tx;
	} dpb_pins_t;

	// Interrupt acknowledge answer.
	typedef struct packed {
		logic ack;
		logic vec_oe;
		logic [7:0] vec;
	} dpb_iack_t;

endpackage

`default_nettype wire

// >>> dpb_properties.sv
/* Port checks for dpb_bus_if. Assumes it is bound to that module. */
`default_nettype none
module dpb_properties (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic PREADY,
	input wire dpb_pkg::dpb_pins_t CH_PINS,
	input wire logic INTSEL,
	input wire logic IACK_A1,
	input wire dpb_pkg::dpb_iack_t IACK,
	input wire logic IRQ_LINE_ZERO_N
);
	import dpb_pkg::*;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// ==========================================================
	// Checks.
	a_reset_safe: assert property ($past(RST) |-> !CH_PINS && IRQ_LINE_ZERO_N)
		else $error("reset");
	a_half_duplex: assert property (!(CH_PINS.tx & ~CH_PINS.drive_en)) else $error("tx");
	a_zero_wait: assert property (PSEL && PENABLE |-> PREADY) else $error("wait");
	a_ack_vector: assert property ($rose(INTSEL) && !IACK_A1 |=> IACK.ack && IACK.vec_oe)
		else $error("ack");
	a_a1_ignored: assert property ($rose(INTSEL) && IACK_A1 |=> !IACK.ack) else $error("a1");
	a_ack_single: assert property (IACK.ack |=> !IACK.ack) else $error("pulse");
	a_oe_release: assert property (!INTSEL [*2] |=> !IACK.vec_oe) else $error("oe");
	a_irq_hold: assert property (!IRQ_LINE_ZERO_N && !(PSEL && PWRITE)
		&& !$past(PSEL && PWRITE) |=> !IRQ_LINE_ZERO_N) else $error("irq");
endmodule
bind dpb_bus_if dpb_properties prop_u (.*);
`default_nettype wire

// >>> tb_diff_io_pack_bus_interface.sv
/* Bench for dpb_bus_if. Assumes dpb_host and the checker compile first. */
`default_nettype none
module tb_diff_io_pack_bus_interface;
	timeunit 1ns;
	timeprecision 1ns;
	import dpb_pkg::*;
	logic MCLK = 1'b0;
	logic RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, INTSEL, IACK_A1, IRQ_LINE_ZERO_N;
	logic go, got;
	logic [7:0] PADDR, vec, ve;
	logic [23:0] CH_RX;
	logic [31:0] PWDATA, PRDATA, rd, d, e, m, seed = 32'h00013740;
	dpb_pins_t CH_PINS;
	dpb_iack_t IACK;
	int err_count, num_checks, n;
	always #20 MCLK = ~MCLK;
	dpb_bus_if dut_u (.*);
	dpb_host host_u (.clk(MCLK), .rst(RST), .go(go), .ack(IACK), .intsel(INTSEL), .vec(vec),
		.got(got));
	// ==========================================================
	// Helpers.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", s, x, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		m = 32'(PSLVERR);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge MCLK);
	endtask
	task automatic pulse_go();
		go <= 1'b1;
		@(posedge MCLK);
		go <= 1'b0;
		repeat (6) @(posedge MCLK);
	endtask
	task complete_run();
		if (err_count == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// Sequence.
	initial begin
		{RST, PSEL, PENABLE, PWRITE, go, IACK_A1} = 6'h20;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		CH_RX = 24'h0;
		repeat (16) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		d = xs() & 32'hFFFFFF;
		e = xs() & 32'hFFFFFF;
		bus(1'b1, OFF_DIR, d);
		bus(1'b1, OFF_DATA, e);
		CH_RX <= 24'(xs());
		repeat (3) @(posedge MCLK);
		bus(1'b0, OFF_DATA, 32'h0);
		chk("en", 32'(CH_PINS.drive_en), d);
		chk("tx", 32'(CH_PINS.tx), d & e);
		chk("rx", rd & ~d, 32'(CH_RX) & ~d);
		bus(1'b1, OFF_SOFT_RST, 32'h1);
		@(posedge MCLK);
		chk("srst", 32'(|CH_PINS), 32'h0);
		ve = 8'(xs());
		bus(1'b1, OFF_INT_VEC, 32'(ve));
		bus(1'b1, OFF_INT_TYPE, 32'h20);
		bus(1'b1, OFF_INT_EN, 32'h20);
		bus(1'b1, OFF_INT_STAT, 32'hFFFFFF);
		CH_RX[5] <= ~CH_RX[5];
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (IRQ_LINE_ZERO_N !== 1'b0 && n < 99);
		chk("lat", 32'(n <= IRQ_MAX_CYC), 32'h1);
		bus(1'b0, OFF_INT_STAT, 32'h0);
		chk("stat", rd, 32'h20);
		pulse_go();
		chk("vec", 32'({got, vec}), {23'h0, 1'b1, ve});
		chk("hold", 32'(IRQ_LINE_ZERO_N), 32'h0);
		IACK_A1 <= 1'b1;
		pulse_go();
		chk("a1", 32'({got, IACK.vec_oe}), 32'h0);
		bus(1'b1, OFF_INT_STAT, 32'h20);
		@(posedge MCLK);
		chk("clr", 32'(IRQ_LINE_ZERO_N), 32'h1);
		bus(1'b1, OFF_INT_POL, 32'(CH_RX) & 32'h20);
		bus(1'b1, OFF_INT_TYPE, 32'h0);
		bus(1'b1, OFF_INT_STAT, 32'h20);
		repeat (3) @(posedge MCLK);
		chk("relvl", 32'(IRQ_LINE_ZERO_N), 32'h0);
		bus(1'b0, 8'h20, 32'h0);
		chk("err", m, 32'h1);
		bus(1'b0, OFF_ID_BASE, 32'h0);
		chk("id", rd, 32'h49);
		complete_run();
	end
	initial begin
		repeat (2000) @(posedge MCLK);
		err_count++;
		complete_run();
	end
endmodule
`default_nettype wire
